// ===== rtl/link_user_data_defs.svh
`ifndef LINK_USER_DATA_DEFS_SVH
`define LINK_USER_DATA_DEFS_SVH

// Lane count sets the bus width
`define LUD_LANES        1
`define LUD_LANE_BITS    64
`define LUD_DATA_W       (`LUD_LANE_BITS * `LUD_LANES)
`define LUD_KEEP_W       (`LUD_DATA_W / 8)
`define LUD_KEEP_ALL     8'hFF
`define LUD_FIFO_DEPTH   8
`define LUD_CLK_PERIOD_NS 50
`define LUD_CRC_INIT     32'hFFFFFFFF
`define LUD_CRC_POLY     32'hEDB88320
`define LUD_CRC_XOROUT   32'hFFFFFFFF

`endif

// ===== rtl/link_user_data_pkg.sv
package link_user_data_pkg;

  // Frame tracking for per-frame CRC start
  typedef enum logic [0:0] {
    FRM_IDLE = 1'b0,
    FRM_BODY = 1'b1
  } frame_state_t;

endpackage

// ===== rtl/link_user_data_port.sv
// Operation
// RULE1 - Transmit beat taken only when accept and source valid both high on an edge.
// RULE2 - Source drives valid only with meaningful data; otherwise inputs are ignored.
// RULE3 - Source raises frame-last on the final beat of every frame.
// RULE4 - Last-beat byte count is set keep bits; FF means eight; keep used only with last.
// RULE5 - Source packs valid bytes contiguously from the least significant end.
// RULE6 - Continuous aligned and unaligned transmit streams are both accepted.
// RULE7 - Receive valid marks meaningful outputs; sink ignores outputs while it is low.
// RULE8 - Receive keep reports valid bytes, meaningful only on the last beat.
// RULE9 - Receive frame-last is high for exactly one cycle, ending each frame.
// RULE10 - With CRC enabled a CRC32 is computed over every frame passing through.
// RULE11 - Data width is 64 bits per lane, one keep bit per byte.
// RULE12 - Streaming mode has only data, valid, ready; framing adds last and keep.
// RULE13 - Full duplex has both directions; simplex only its one direction.
// RULE14 - Buses are numbered ascending; index 0 is the first bit.
// RULE15 - Framing mode presents received channel data on the receive bus with valid.
// RULE16 - All transfers sample on the rising clock; receive has no backpressure.
`timescale 1ns/10ps
`include "link_user_data_defs.svh"

module link_user_data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Ready registered off next count, so full is honest
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r    <= '0;
      o_in_ready <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      o_in_ready <= (count_nxt < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage needs no reset; guarded by count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end
endmodule

module link_user_data_port #(
  parameter bit FRAMING = 1'b1,
  parameter bit TX_EN   = 1'b1,
  parameter bit RX_EN   = 1'b1,
  parameter bit CRC_EN  = 1'b1
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_nrst,
  // Application transmit side
  input  wire logic [0:`LUD_DATA_W-1]   i_tx_data,
  input  wire logic                     i_tx_source_valid,
  input  wire logic                     i_tx_frame_last,
  input  wire logic [0:`LUD_KEEP_W-1]   i_tx_byte_keep,
  output logic                          o_tx_accept,
  // Protocol engine transmit side
  output logic [0:`LUD_DATA_W-1]        o_ch_tx_data,
  output logic                          o_ch_tx_valid,
  output logic                          o_ch_tx_last,
  output logic [0:`LUD_KEEP_W-1]        o_ch_tx_keep,
  input  wire logic                     i_ch_tx_ready,
  output logic [31:0]                   o_tx_crc,
  output logic                          o_tx_crc_valid,
  // Protocol engine receive side
  input  wire logic [0:`LUD_DATA_W-1]   i_ch_rx_data,
  input  wire logic                     i_ch_rx_valid,
  input  wire logic                     i_ch_rx_last,
  input  wire logic [0:`LUD_KEEP_W-1]   i_ch_rx_keep,
  // Application receive side
  output logic [0:`LUD_DATA_W-1]        o_rx_data,
  output logic                          o_rx_out_valid,
  output logic                          o_rx_frame_last,
  output logic [0:`LUD_KEEP_W-1]        o_rx_byte_keep,
  output logic [31:0]                   o_rx_crc,
  output logic                          o_rx_crc_valid
);
  // RULE11 64 bits per lane
  localparam int DW = `LUD_DATA_W;
  localparam int KW = `LUD_KEEP_W;
  localparam int FW = DW + KW + 1;

  logic          rst_meta_r;
  logic          rst_n_r;
  logic [FW-1:0] fifo_in;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic [FW-1:0] fifo_out;
  logic          fifo_out_valid;
  logic          stage_load;
  logic          fifo_last;
  logic [0:KW-1] fifo_keep;
  logic          ch_fire;
  logic [31:0]   tx_crc_r;
  logic [31:0]   tx_crc_nxt;
  logic [31:0]   rx_crc_r;
  logic [31:0]   rx_crc_nxt;
  link_user_data_pkg::frame_state_t tx_frm_r;
  link_user_data_pkg::frame_state_t rx_frm_r;

  // RULE14 index 0 leftmost
  // CRC32 over the kept bytes of one beat, byte 0 first, bit 0 first
  function automatic logic [31:0] crc_beat(input logic [31:0]   crc_in,
                                           input logic [0:DW-1] data,
                                           input logic [0:KW-1] keep);
    logic [31:0] c;
    logic        fb;
    c = crc_in;
    for (int b = 0; b < KW; b++) begin
      if (keep[b]) begin
        for (int j = 0; j < 8; j++) begin
          fb = c[0] ^ data[8*b + j];
          c  = {1'b0, c[31:1]} ^ (fb ? `LUD_CRC_POLY : 32'h00000000);
        end
      end
    end
    return c;
  endfunction

  // Async assert, synchronous release
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // RULE12 streaming drops last and keep
  // RULE4 keep sampled only with last
  assign fifo_in = {FRAMING & i_tx_frame_last,
                    (FRAMING & i_tx_frame_last) ? i_tx_byte_keep : `LUD_KEEP_ALL,
                    i_tx_data};
  // RULE1 beat taken on valid and accept
  // RULE13 transmit absent in RX-only build
  assign fifo_in_valid = TX_EN & i_tx_source_valid;
  assign fifo_last     = fifo_out[FW-1];
  assign fifo_keep     = fifo_out[DW +: KW];
  assign ch_fire       = o_ch_tx_valid && i_ch_tx_ready;
  assign stage_load    = !o_ch_tx_valid || i_ch_tx_ready;

  link_user_data_fifo #(
    .WIDTH (FW),
    .DEPTH (`LUD_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_sys_clk),
    .i_rst_n     (rst_n_r),
    .i_in_data   (fifo_in),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (stage_load)
  );

  // Accept is the FIFO's registered ready
  assign o_tx_accept = TX_EN & fifo_in_ready;

  // Output stage toward the protocol engine; stalls back into FIFO
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_ch_tx_valid <= 1'b0;
      o_ch_tx_last  <= 1'b0;
      o_ch_tx_keep  <= '0;
      o_ch_tx_data  <= '0;
    end else if (stage_load) begin
      // RULE6 aligned or unaligned back to back
      o_ch_tx_valid <= fifo_out_valid;
      o_ch_tx_last  <= fifo_out_valid & fifo_last;
      o_ch_tx_keep  <= fifo_keep;
      o_ch_tx_data  <= fifo_out[DW-1:0];
    end
  end

  always_comb begin
    tx_crc_nxt = crc_beat((tx_frm_r == link_user_data_pkg::FRM_IDLE) ?
                          `LUD_CRC_INIT : tx_crc_r, o_ch_tx_data, o_ch_tx_keep);
  end

  // RULE10 transmit frame CRC
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_crc_r       <= `LUD_CRC_INIT;
      tx_frm_r       <= link_user_data_pkg::FRM_IDLE;
      o_tx_crc       <= 32'h00000000;
      o_tx_crc_valid <= 1'b0;
    end else begin
      o_tx_crc_valid <= 1'b0;
      if (CRC_EN && FRAMING && ch_fire) begin
        tx_crc_r <= tx_crc_nxt;
        if (o_ch_tx_last) begin
          tx_frm_r       <= link_user_data_pkg::FRM_IDLE;
          o_tx_crc       <= tx_crc_nxt ^ `LUD_CRC_XOROUT;
          o_tx_crc_valid <= 1'b1;
        end else begin
          tx_frm_r <= link_user_data_pkg::FRM_BODY;
        end
      end
    end
  end

  // Receive: no backpressure, every channel beat is passed on
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rx_out_valid  <= 1'b0;
      o_rx_frame_last <= 1'b0;
      o_rx_byte_keep  <= '0;
      o_rx_data       <= '0;
    end else begin
      // RULE16 sink must take every beat
      // RULE7 valid qualifies outputs
      o_rx_out_valid  <= RX_EN & i_ch_rx_valid;
      // RULE9 last lasts one beat only
      o_rx_frame_last <= RX_EN & FRAMING & i_ch_rx_valid & i_ch_rx_last;
      // RULE8 keep meaningful with last
      o_rx_byte_keep  <= (RX_EN & FRAMING & i_ch_rx_valid & i_ch_rx_last) ?
                         i_ch_rx_keep : '0;
      // RULE15 received frame data
      if (RX_EN && i_ch_rx_valid) begin
        o_rx_data <= i_ch_rx_data;
      end
    end
  end

  always_comb begin
    rx_crc_nxt = crc_beat((rx_frm_r == link_user_data_pkg::FRM_IDLE) ?
                          `LUD_CRC_INIT : rx_crc_r, o_rx_data,
                          o_rx_frame_last ? o_rx_byte_keep : `LUD_KEEP_ALL);
  end

  // RULE10 receive frame CRC
  always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_crc_r       <= `LUD_CRC_INIT;
      rx_frm_r       <= link_user_data_pkg::FRM_IDLE;
      o_rx_crc       <= 32'h00000000;
      o_rx_crc_valid <= 1'b0;
    end else begin
      o_rx_crc_valid <= 1'b0;
      if (CRC_EN && FRAMING && o_rx_out_valid) begin
        rx_crc_r <= rx_crc_nxt;
        if (o_rx_frame_last) begin
          rx_frm_r       <= link_user_data_pkg::FRM_IDLE;
          o_rx_crc       <= rx_crc_nxt ^ `LUD_CRC_XOROUT;
          o_rx_crc_valid <= 1'b1;
        end else begin
          rx_frm_r <= link_user_data_pkg::FRM_BODY;
        end
      end
    end
  end
endmodule

// ===== verif/lud_sva.sv
`timescale 1ns/10ps
`include "link_user_data_defs.svh"
module lud_sva #(
  parameter bit FRAMING = 1'b1
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_nrst,
  input wire logic [0:`LUD_DATA_W-1] o_ch_tx_data,
  input wire logic                   o_ch_tx_valid,
  input wire logic                   o_ch_tx_last,
  input wire logic [0:`LUD_KEEP_W-1] o_ch_tx_keep,
  input wire logic                   i_ch_tx_ready,
  input wire logic                   o_tx_crc_valid,
  input wire logic [0:`LUD_DATA_W-1] i_ch_rx_data,
  input wire logic                   i_ch_rx_valid,
  input wire logic                   i_ch_rx_last,
  input wire logic [0:`LUD_KEEP_W-1] i_ch_rx_keep,
  input wire logic [0:`LUD_DATA_W-1] o_rx_data,
  input wire logic                   o_rx_out_valid,
  input wire logic                   o_rx_frame_last,
  input wire logic [0:`LUD_KEEP_W-1] o_rx_byte_keep,
  input wire logic                   o_rx_crc_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_rx_valid_lat: assert property (
    o_rx_out_valid == $past(i_ch_rx_valid)) else $error("rx valid latency");
  a_rx_last_match: assert property (
    o_rx_frame_last == (FRAMING && $past(i_ch_rx_valid && i_ch_rx_last)))
    else $error("rx last");
  a_rx_data_fwd: assert property (
    i_ch_rx_valid |=> o_rx_data == $past(i_ch_rx_data)) else $error("rx data");
  a_rx_keep_last: assert property (
    FRAMING && i_ch_rx_valid && i_ch_rx_last |=> o_rx_byte_keep == $past(i_ch_rx_keep))
    else $error("rx keep");
  a_tx_hold_stall: assert property (
    o_ch_tx_valid && !i_ch_tx_ready |=> o_ch_tx_valid && $stable(o_ch_tx_data)
    && $stable(o_ch_tx_last)) else $error("tx stage not held");
  a_tx_keep_full: assert property (
    o_ch_tx_valid && !o_ch_tx_last |-> o_ch_tx_keep == 8'hFF) else $error("tx keep");
  a_tx_crc_done: assert property (
    o_ch_tx_valid && i_ch_tx_ready && o_ch_tx_last |=> o_tx_crc_valid)
    else $error("tx crc valid");
  a_rx_crc_done: assert property (
    o_rx_frame_last |=> o_rx_crc_valid) else $error("rx crc valid");
  c_tx_stall: cover property (o_ch_tx_valid && !i_ch_tx_ready);
  c_rx_last: cover property (o_rx_frame_last);
  c_tx_crc: cover property (o_tx_crc_valid);
endmodule
bind link_user_data_port lud_sva #(.FRAMING(FRAMING)) u_sva (.*);

// ===== verif/lud_engine_model.sv
`timescale 1ns/10ps
`include "link_user_data_defs.svh"
module lud_engine_model (
  input wire logic                   i_clk,
  input wire logic                   i_valid,
  input wire logic [0:`LUD_DATA_W-1] i_data,
  input wire logic                   i_last,
  input wire logic [0:`LUD_KEEP_W-1] i_keep,
  input wire logic                   i_stall,
  output logic                       o_ready
);
  logic [72:0] q[$];
  initial o_ready = 1'b0;
  always @(posedge i_clk) o_ready <= !i_stall;
  always @(posedge i_clk) if (i_valid && o_ready) q.push_back({i_last, i_keep, i_data});
endmodule

// ===== verif/link_user_data_port_tb_top.sv
`timescale 1ns/10ps
`include "link_user_data_defs.svh"
module link_user_data_port_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [0:63] tx_d = '0, chd, rxd = '0, od;
  logic [0:7]  tx_k = '0, chk, rxk = '0, ok;
  logic        tx_v = 1'b0, tx_l = 1'b0, acc, chv, chl, rdy, stall = 1'b0;
  logic        rxv = 1'b0, rxl = 1'b0, ov, ol;
  logic [31:0] txc, rxc;
  logic        s_acc, s_chv, s_ol;
  logic [0:7]  s_ok;
  logic [0:63] s_od;
  int          n_mismatch = 0;
  int          comparisons = 0;
  initial forever #25 clk = ~clk;
  link_user_data_port dut (.i_sys_clk(clk), .i_nrst(nrst), .i_tx_data(tx_d),
    .i_tx_source_valid(tx_v), .i_tx_frame_last(tx_l), .i_tx_byte_keep(tx_k),
    .o_tx_accept(acc), .o_ch_tx_data(chd), .o_ch_tx_valid(chv), .o_ch_tx_last(chl),
    .o_ch_tx_keep(chk), .i_ch_tx_ready(rdy), .o_tx_crc(txc), .o_tx_crc_valid(),
    .i_ch_rx_data(rxd), .i_ch_rx_valid(rxv), .i_ch_rx_last(rxl), .i_ch_rx_keep(rxk),
    .o_rx_data(od), .o_rx_out_valid(ov), .o_rx_frame_last(ol), .o_rx_byte_keep(ok),
    .o_rx_crc(rxc), .o_rx_crc_valid());
  // Receive-only streaming build on the same stimulus
  link_user_data_port #(.FRAMING(1'b0), .TX_EN(1'b0)) dut_s (.i_sys_clk(clk), .i_nrst(nrst),
    .i_tx_data(tx_d), .i_tx_source_valid(tx_v), .i_tx_frame_last(tx_l), .i_tx_byte_keep(tx_k),
    .o_tx_accept(s_acc), .o_ch_tx_data(), .o_ch_tx_valid(s_chv), .o_ch_tx_last(),
    .o_ch_tx_keep(), .i_ch_tx_ready(rdy), .o_tx_crc(), .o_tx_crc_valid(),
    .i_ch_rx_data(rxd), .i_ch_rx_valid(rxv), .i_ch_rx_last(rxl), .i_ch_rx_keep(rxk),
    .o_rx_data(s_od), .o_rx_out_valid(), .o_rx_frame_last(s_ol), .o_rx_byte_keep(s_ok),
    .o_rx_crc(), .o_rx_crc_valid());
  lud_engine_model eng (.i_clk(clk), .i_valid(chv), .i_data(chd), .i_last(chl),
    .i_keep(chk), .i_stall(stall), .o_ready(rdy));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [72:0] e, input logic [72:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Reference CRC32, reflected, byte 0 and bit 0 first
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [0:63] d,
                                          input logic [0:7] k);
    for (int b = 0; b < 8; b++) begin
      for (int j = 0; j < 8; j++) begin
        if (k[b]) c = (c >> 1) ^ ((c[0] ^ d[8*b+j]) ? `LUD_CRC_POLY : 32'h00000000);
      end
    end
    return c;
  endfunction
  task automatic timeout(input string nm);
    n_mismatch++;
    $display("[FAIL] %s exp handshake got none", nm);
    print_verdict();
  endtask
  // idle data meaningless
  // Released data lines show the inverse, not the old beat; last and keep hold
  task automatic idle_tx();
    tx_v = 1'b0;
    tx_d = ~tx_d;
  endtask
  task automatic send(input logic [63:0] d, input logic l, input logic [7:0] k);
    tx_d = d;
    tx_l = l;
    tx_k = k;
    tx_v = 1'b1;
    // Accept is registered, so it stands through the next rise
    for (int i = 0; i < 100; i++) begin
      if (acc === 1'b1) begin
        @(negedge clk);
        return;
      end
      @(negedge clk);
    end
    timeout("tx accept");
  endtask
  task automatic check_q(input int n, input int lst, input logic [7:0] k, input logic [63:0] b);
    for (int i = 0; i < 100 && eng.q.size() < n; i++) @(negedge clk);
    if (eng.q.size() < n) timeout("engine beats");
    for (int i = 0; i < n; i++) begin
      cmp("tx beat", {i == lst, i == lst ? k : 8'hFF, b + i}, eng.q.pop_front());
    end
  endtask
  task automatic test_tx_frame();
    logic [31:0] c;
    c = `LUD_CRC_INIT;
    cmp("simplex accept", 0, s_acc);
    for (int i = 0; i < 3; i++) begin
      send(64'hA5A5_0000_0000_0000 + i, i == 2, i == 2 ? 8'hF0 : 8'h00);
      c = crc_ref(c, 64'hA5A5_0000_0000_0000 + i, i == 2 ? 8'hF0 : 8'hFF);
    end
    idle_tx();
    check_q(3, 2, 8'hF0, 64'hA5A5_0000_0000_0000);
    cmp("tx crc", c ^ `LUD_CRC_XOROUT, txc);
    $display("test_tx_frame done");
  endtask
  task automatic test_tx_stall();
    int n;
    logic [31:0] c;
    n = 0;
    c = `LUD_CRC_INIT;
    stall = 1'b1;
    repeat (2) @(negedge clk);
    tx_v = 1'b1;
    tx_k = 8'hC0;
    for (int i = 0; i < 30; i++) begin
      tx_d = 64'h5A00 + n;
      tx_l = n == 9;
      if (acc === 1'b1) n++;
      @(negedge clk);
    end
    cmp("beats taken while stalled", `LUD_FIFO_DEPTH + 1, n);
    cmp("simplex tx valid", 0, s_chv);
    stall = 1'b0;
    send(64'h5A09, 1'b1, 8'hC0);
    idle_tx();
    check_q(10, 9, 8'hC0, 64'h5A00);
    for (int i = 0; i < 10; i++) c = crc_ref(c, 64'h5A00 + i, i == 9 ? 8'hC0 : 8'hFF);
    cmp("tx crc stalled", c ^ `LUD_CRC_XOROUT, txc);
    $display("test_tx_stall done");
  endtask
  task automatic test_rx();
    logic [31:0] c;
    c = `LUD_CRC_INIT;
    for (int i = 0; i < 3; i++) begin
      rxd = 64'hC3C3_0000_0000_0000 + i;
      rxv = 1'b1;
      rxl = i == 2;
      rxk = 8'hFC;
      c = crc_ref(c, rxd, i == 2 ? 8'hFC : 8'hFF);
      @(negedge clk);
      cmp("rx valid", 1, ov);
      cmp("rx data", rxd, od);
      cmp("rx last", i == 2, ol);
      cmp("stream rx data", rxd, s_od);
      if (i == 2) cmp("rx keep", 8'hFC, ok);
      if (i == 2) cmp("stream rx last", 0, s_ol);
      if (i == 2) cmp("stream rx keep", 0, s_ok);
    end
    rxv = 1'b0;
    rxd = ~rxd;
    rxl = 1'b0;
    @(negedge clk);
    cmp("rx valid idle", 0, ov);
    cmp("rx last idle", 0, ol);
    cmp("rx crc", c ^ `LUD_CRC_XOROUT, rxc);
    $display("test_rx done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    cmp("accept in reset", 0, acc);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    test_tx_frame();
    test_tx_stall();
    test_rx();
    print_verdict();
  end
endmodule
